// >>> bench/tbst_core_tb.sv
// Self-checking bench for the trace buffer status and trigger counter block
`timescale 1ns/1ps
module tbst_core_tb
    import tbst_pkg::*;
;
    logic clk_i, rst_b_i, reg_req_i, reg_wr_i, reg_ack_o;
    logic [TBST_ADDR_W-1:0] reg_addr_i;
    logic [TBST_DATA_W-1:0] reg_wdata_i, reg_rdata_o;
    logic capture_enable_i, scatter_i, disabled_i, stopped_i, pipes_drained_i, mem_busy_i;
    logic memory_error_flag_i, mem_no_data_i, mem_full_i, wp_wrap_i;
    logic [1:0] mode_i;
    logic [31:0] fill_level_i, buffer_size_words_i, buffer_watermark_i;
    logic trigger_detected_i, word_captured_i, trigger_event_o;
    logic capture_idle_flag_o, formatter_drained_flag_o, buffer_empty_flag_o;
    logic triggered_flag_o, buffer_full_flag_o;
    int mismatches = 0;
    int checks = 0;
    integer seed = 78;
    logic [31:0] notes[$];
    logic [31:0] rnd;

    tbst_core uut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_ack_o(reg_ack_o),
        .reg_rdata_o(reg_rdata_o), .capture_enable_i(capture_enable_i), .mode_i(mode_i),
        .scatter_i(scatter_i), .disabled_i(disabled_i), .stopped_i(stopped_i),
        .pipes_drained_i(pipes_drained_i), .mem_busy_i(mem_busy_i),
        .memory_error_flag_i(memory_error_flag_i), .mem_no_data_i(mem_no_data_i),
        .mem_full_i(mem_full_i), .wp_wrap_i(wp_wrap_i), .fill_level_i(fill_level_i),
        .buffer_size_words_i(buffer_size_words_i), .buffer_watermark_i(buffer_watermark_i),
        .trigger_detected_i(trigger_detected_i), .word_captured_i(word_captured_i),
        .trigger_event_o(trigger_event_o), .capture_idle_flag_o(capture_idle_flag_o),
        .formatter_drained_flag_o(formatter_drained_flag_o),
        .buffer_empty_flag_o(buffer_empty_flag_o), .triggered_flag_o(triggered_flag_o),
        .buffer_full_flag_o(buffer_full_flag_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Every step call ends 1 ns after a rising edge, so acc and sts start and end there too
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Writes answer with zero read data, so every access leaves a note
    task automatic acc(input logic wr, input logic [11:0] addr, input logic [31:0] d,
                       input logic [31:0] exp);
        notes.push_back(exp);
        reg_req_i = 1'b1;
        reg_wr_i = wr;
        reg_addr_i = addr;
        reg_wdata_i = d;
        step(1);
        reg_req_i = 1'b0;
        // An edge passes with the request low, so back-to-back calls are seen as separate requests
        step(1);
    endtask

    // Flag pins and the status read must agree with the same expected word
    task automatic sts(input logic [31:0] exp);
        step(2);
        chk("status pins", exp, {27'h0, buffer_empty_flag_o, formatter_drained_flag_o,
                                 capture_idle_flag_o, triggered_flag_o, buffer_full_flag_o});
        acc(1'b0, TBST_OFS_STATUS, 32'h0, exp);
    endtask

    // Answers are compared away from the edge that launches them
    always @(negedge clk_i) begin
        if (reg_ack_o === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected answer", 32'h0, 32'hFFFF_FFFF);
            end else begin
                chk("register read data", notes.pop_front(), reg_rdata_o);
            end
        end
    end

    initial begin
        #20000;
        mismatches++;
        finish_test();
    end

    initial begin
        {reg_req_i, reg_wr_i, reg_addr_i, reg_wdata_i} = '0;
        {capture_enable_i, mode_i, scatter_i, stopped_i, mem_busy_i} = '0;
        {memory_error_flag_i, mem_full_i, wp_wrap_i, trigger_detected_i} = '0;
        {disabled_i, pipes_drained_i, mem_no_data_i, word_captured_i} = 4'h E;
        fill_level_i = 32'h0;
        buffer_size_words_i = 32'h40;
        buffer_watermark_i = 32'h10;
        rst_b_i = 1'b0;
        step(2);
        chk("idle flag in reset", 32'h1, {31'h0, capture_idle_flag_o});
        step(1);
        rst_b_i = 1'b1;
        sts(32'h0C);
        acc(1'b1, TBST_OFS_TRGCNT, 32'h2, 32'h0);
        acc(1'b0, TBST_OFS_TRGCNT, 32'h0, 32'h2);
        acc(1'b0, 12'h010, 32'h0, 32'h0);
        acc(1'b1, 12'h010, 32'hFFFF_FFFF, 32'h0);
        acc(1'b0, TBST_OFS_TRGCNT, 32'h0, 32'h2);
        {disabled_i, capture_enable_i, pipes_drained_i} = 3'h2;
        sts(32'h10);
        trigger_detected_i = 1'b1;
        step(1);
        trigger_detected_i = 1'b0;
        word_captured_i = 1'b1;
        step(1);
        word_captured_i = 1'b0;
        acc(1'b0, TBST_OFS_STATUS, 32'h0, 32'h10);
        word_captured_i = 1'b1;
        step(1);
        chk("trigger event", 32'h1, {31'h0, trigger_event_o});
        word_captured_i = 1'b0;
        sts(32'h12);
        wp_wrap_i = 1'b1;
        step(1);
        wp_wrap_i = 1'b0;
        sts(32'h13);
        mem_no_data_i = 1'b0;
        sts(32'h03);
        acc(1'b1, TBST_OFS_STATUS, 32'h0, 32'h0);
        sts(32'h02);
        mode_i = TBST_MODE_SWFIFO1;
        for (int i = 0; i < 6; i++) begin
            rnd = $random(seed);
            fill_level_i = (i < 2) ? 32'h2F + i : {26'h0, rnd[5:0]};
            sts({31'h0, fill_level_i >= 32'h30});
        end
        scatter_i = 1'b1;
        fill_level_i = 32'h3C;
        for (int i = 0; i < 2; i++) begin
            mem_full_i = i[0];
            sts({31'h0, mem_full_i});
        end
        scatter_i = 1'b0;
        sts(32'h01);
        {disabled_i, mem_no_data_i} = 2'h3;
        fill_level_i = 32'h0;
        sts(32'h01);
        {pipes_drained_i, mem_busy_i} = 2'h3;
        sts(32'h09);
        mem_busy_i = 1'b0;
        sts(32'h0D);
        mode_i = TBST_MODE_CIRCULAR;
        sts(32'h0F);
        {disabled_i, stopped_i} = 2'h1;
        sts(32'h1D);
        {stopped_i, memory_error_flag_i} = 2'h1;
        sts(32'h1D);
        memory_error_flag_i = 1'b0;
        sts(32'h11);
        // Mid-run reset once the last answer has been compared
        step(2);
        rst_b_i = 1'b0;
        step(1);
        chk("idle flag in reset", 32'h1, {31'h0, capture_idle_flag_o});
        rst_b_i = 1'b1;
        sts(32'h10);
        acc(1'b0, TBST_OFS_TRGCNT, 32'h0, 32'h0);
        step(3);
        chk("notes left over", 32'h0, notes.size());
        finish_test();
    end
endmodule

// >>> core/tbst_core.sv
// Status flags and post-trigger word counter of a trace capture router
`timescale 1ns/1ps
module tbst_core
    import tbst_pkg::*;
#(
    parameter bit FORMATTER_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic reg_req_i,
    input wire logic reg_wr_i,
    input wire logic [TBST_ADDR_W-1:0] reg_addr_i,
    input wire logic [TBST_DATA_W-1:0] reg_wdata_i,
    output logic reg_ack_o,
    output logic [TBST_DATA_W-1:0] reg_rdata_o,
    // Capture control and state
    input wire logic capture_enable_i,
    input wire logic [1:0] mode_i,
    input wire logic scatter_i,
    input wire logic disabled_i,
    input wire logic stopped_i,
    input wire logic pipes_drained_i,
    input wire logic mem_busy_i,
    input wire logic memory_error_flag_i,
    // Buffer status
    input wire logic mem_no_data_i,
    input wire logic mem_full_i,
    input wire logic wp_wrap_i,
    input wire logic [31:0] fill_level_i,
    input wire logic [31:0] buffer_size_words_i,
    input wire logic [31:0] buffer_watermark_i,
    // Trigger
    input wire logic trigger_detected_i,
    input wire logic word_captured_i,
    output logic trigger_event_o,
    // Status flags
    output logic capture_idle_flag_o,
    output logic formatter_drained_flag_o,
    output logic buffer_empty_flag_o,
    output logic triggered_flag_o,
    output logic buffer_full_flag_o
);

    // Fill level at or above size minus watermark; watermark past size counts as full
    function automatic logic level_full(input logic [31:0] lvl, input logic [31:0] sz,
                                        input logic [31:0] wm);
        logic [32:0] room;
        room = {1'b0, sz} - {1'b0, wm};
        level_full = room[32] | ({1'b0, lvl} >= room);
    endfunction

    tbst_state_t st_r;
    tbst_state_t st_nxt;

    logic circ;
    logic capturing;
    logic leaving_dis;
    logic sts_wr;
    logic trg_wr;
    logic err_stop;
    logic idle_cond;
    logic drained_cond;
    logic fifo_full;

    // All inputs come from logic on this clock, so none is synchronised
    assign circ = (mode_i == TBST_MODE_CIRCULAR);
    assign capturing = capture_enable_i & ~disabled_i & ~stopped_i;
    assign leaving_dis = st_r.dis_q & ~disabled_i;
    assign sts_wr = reg_req_i & reg_wr_i & (reg_addr_i == TBST_OFS_STATUS);
    assign trg_wr = reg_req_i & reg_wr_i & (reg_addr_i == TBST_OFS_TRGCNT);
    // A memory error halts the formatter, which then counts as stopped
    assign err_stop = FORMATTER_PRESENT & memory_error_flag_i;
    assign idle_cond = (stopped_i | disabled_i | err_stop) & pipes_drained_i & ~mem_busy_i;
    // Memory traffic is left out on purpose so buffer drains do not disturb it
    assign drained_cond = (stopped_i | disabled_i | err_stop) & pipes_drained_i;
    // Scatter reports the true memory state; a late table read may stall silently
    assign fifo_full = scatter_i ? mem_full_i
        : level_full(fill_level_i, buffer_size_words_i, buffer_watermark_i);

    always_comb begin
        st_nxt = st_r;
        st_nxt.dis_q = disabled_i;
        st_nxt.idle = idle_cond;
        st_nxt.drained = drained_cond;
        st_nxt.tevent = 1'b0;

        // Empty tracks live outside Disabled and freezes inside it
        if (!disabled_i) begin
            st_nxt.empty = capture_enable_i & mem_no_data_i;
        end

        // Full: software may load it while Disabled or in circular mode; hardware wins in the same cycle
        if (sts_wr) begin
            st_nxt.full = reg_wdata_i[TBST_BIT_FULL];
        end
        if (!disabled_i) begin
            if (circ) begin
                if (wp_wrap_i) begin
                    st_nxt.full = 1'b1;
                end
            end else begin
                st_nxt.full = fifo_full;
            end
        end

        if (trg_wr) begin
            st_nxt.trg_cnt = reg_wdata_i;
        end

        // Post-trigger word countdown
        case (st_r.tstate)
            TBST_TRG_IDLE: begin
                if (trigger_detected_i && circ && capturing) begin
                    if (st_r.trg_cnt == 32'h0000_0000) begin
                        st_nxt.tevent = 1'b1;
                        st_nxt.tstate = TBST_TRG_DONE;
                    end else begin
                        st_nxt.down = st_r.trg_cnt;
                        st_nxt.tstate = TBST_TRG_COUNT;
                    end
                end
            end
            TBST_TRG_COUNT: begin
                if (!capturing) begin
                    st_nxt.tstate = TBST_TRG_IDLE;
                end else if (word_captured_i) begin
                    st_nxt.down = st_r.down - 32'h0000_0001;
                    if (st_r.down == 32'h0000_0001) begin
                        st_nxt.tevent = 1'b1;
                        st_nxt.tstate = TBST_TRG_DONE;
                    end
                end
            end
            TBST_TRG_DONE: begin
                // One trigger per session; rearmed when Disabled is entered
                if (disabled_i) begin
                    st_nxt.tstate = TBST_TRG_IDLE;
                end
            end
            default: begin
                st_nxt.tstate = TBST_TRG_IDLE;
            end
        endcase

        // Triggered: clear on exit from Disabled takes priority over a new event
        if (leaving_dis) begin
            st_nxt.trig = 1'b0;
        end else if (st_nxt.tevent && circ && capturing) begin
            st_nxt.trig = 1'b1;
        end

        // Register read path; unmapped offsets read as zero
        st_nxt.ack = reg_req_i;
        st_nxt.rdata = 32'h0000_0000;
        if (reg_req_i && !reg_wr_i) begin
            if (reg_addr_i == TBST_OFS_STATUS) begin
                st_nxt.rdata[TBST_BIT_EMPTY] = st_r.empty;
                st_nxt.rdata[TBST_BIT_DRAINED] = st_r.drained;
                st_nxt.rdata[TBST_BIT_IDLE] = st_r.idle;
                st_nxt.rdata[TBST_BIT_TRIGGERED] = st_r.trig & circ;
                st_nxt.rdata[TBST_BIT_FULL] = st_r.full;
            end else if (reg_addr_i == TBST_OFS_TRGCNT) begin
                st_nxt.rdata = st_r.trg_cnt;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.idle <= TBST_RST_IDLE;
            st_r.empty <= TBST_RST_EMPTY;
            st_r.full <= TBST_RST_FULL;
            st_r.dis_q <= TBST_RST_DISABLED;
            st_r.tstate <= TBST_TRG_IDLE;
            st_r.trg_cnt <= TBST_RST_TRGCNT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_ack_o = st_r.ack;
    assign reg_rdata_o = st_r.rdata;
    assign trigger_event_o = st_r.tevent;
    // Software must poll idle, not empty, to know internal data has reached memory
    assign capture_idle_flag_o = st_r.idle;
    assign formatter_drained_flag_o = st_r.drained;
    assign buffer_empty_flag_o = st_r.empty;
    assign triggered_flag_o = st_r.trig & circ;
    assign buffer_full_flag_o = st_r.full;

    a_empty_live_track: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !disabled_i |=> buffer_empty_flag_o == $past(capture_enable_i & mem_no_data_i))
        else $error("empty flag does not track buffer");

    a_empty_disabled_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        disabled_i |=> $stable(buffer_empty_flag_o))
        else $error("empty flag changed while disabled");

    a_drained_follows_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ((stopped_i | disabled_i) & pipes_drained_i) |=> formatter_drained_flag_o)
        else $error("drained flag missing after stop");

    a_idle_needs_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mem_busy_i | !pipes_drained_i) |=> !capture_idle_flag_o)
        else $error("idle flag set while busy");

    a_idle_after_error: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (FORMATTER_PRESENT & memory_error_flag_i & pipes_drained_i & !mem_busy_i)
        |=> capture_idle_flag_o)
        else $error("idle flag missing after memory error stop");

    a_trig_exit_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (st_r.dis_q && !disabled_i) |=> !st_r.trig)
        else $error("triggered not cleared on leaving disabled");

    a_trig_mode_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mode_i != TBST_MODE_CIRCULAR) |-> !triggered_flag_o)
        else $error("triggered visible outside circular mode");

    a_trig_set_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (trigger_event_o && circ && $past(circ && capturing && !leaving_dis))
        |-> triggered_flag_o)
        else $error("triggered not set on trigger event");

    // Triggered can only move on leaving Disabled or on an event while capturing
    a_trig_hold_dis: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        disabled_i |=> st_r.trig == $past(st_r.trig))
        else $error("triggered changed while disabled");

    a_full_wrap_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (circ && !disabled_i && wp_wrap_i) |=> buffer_full_flag_o)
        else $error("full not set on pointer wrap");

    a_full_fifo_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!circ && !disabled_i && !scatter_i)
        |=> buffer_full_flag_o == $past(level_full(fill_level_i, buffer_size_words_i,
                                                   buffer_watermark_i)))
        else $error("full does not follow fill level");

    a_full_disabled_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (disabled_i && !sts_wr) |=> $stable(buffer_full_flag_o))
        else $error("full changed while disabled");

    a_trg_zero_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (st_r.tstate == TBST_TRG_COUNT && capturing && word_captured_i
         && st_r.down == 32'h0000_0001) |=> trigger_event_o ##1 !trigger_event_o)
        else $error("trigger event not one pulse at count end");

    // A zero count declares the event on the very next cycle
    a_event_zero_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (st_r.tstate == TBST_TRG_IDLE && trigger_detected_i && circ && capturing
         && st_r.trg_cnt == 32'h0000_0000) |=> trigger_event_o)
        else $error("no event for zero trigger count");

    a_trg_count_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (st_r.tstate == TBST_TRG_COUNT && capturing && word_captured_i)
        |=> st_r.down == $past(st_r.down) - 32'h0000_0001)
        else $error("countdown did not step on captured word");

    // Stopping capture mid-count must not leave a stale countdown armed
    a_abort_on_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (st_r.tstate == TBST_TRG_COUNT && !capturing) |=> st_r.tstate == TBST_TRG_IDLE)
        else $error("countdown not aborted on stop");

    a_event_one_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        trigger_event_o |=> !trigger_event_o)
        else $error("trigger event longer than one cycle");

    a_trg_write_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        trg_wr |=> st_r.trg_cnt == $past(reg_wdata_i))
        else $error("trigger count write not loaded");

    a_trg_read_back: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_req_i && !reg_wr_i && reg_addr_i == TBST_OFS_TRGCNT)
        |=> reg_rdata_o == $past(st_r.trg_cnt))
        else $error("trigger count read back wrong");

    // Every request is answered exactly one cycle later, mapped or not
    a_ack_after_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        reg_req_i |=> reg_ack_o)
        else $error("request not answered");

    a_ack_no_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !reg_req_i |=> !reg_ack_o)
        else $error("answer without request");

    a_sts_top_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_req_i && !reg_wr_i && reg_addr_i == TBST_OFS_STATUS)
        |=> reg_rdata_o[TBST_DATA_W-1:TBST_BIT_EMPTY+1] == '0)
        else $error("status upper bits not zero");

    // Unmapped offsets must read zero so software never sees stale data
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_req_i && !reg_wr_i && reg_addr_i != TBST_OFS_STATUS
         && reg_addr_i != TBST_OFS_TRGCNT) |=> reg_rdata_o == '0)
        else $error("unmapped offset read not zero");

    a_write_data_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_req_i && reg_wr_i) |=> reg_rdata_o == '0)
        else $error("write answer carries data");

    a_empty_needs_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!disabled_i && !capture_enable_i) |=> !buffer_empty_flag_o)
        else $error("empty set with capture disabled");

    a_drained_needs_drain: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !pipes_drained_i |=> !formatter_drained_flag_o)
        else $error("drained set with pipelines busy");

    // Memory traffic alone decides between drained and idle once stopped
    a_idle_stop_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ((stopped_i | disabled_i) & pipes_drained_i & !mem_busy_i) |=> capture_idle_flag_o)
        else $error("idle missing when stopped and quiet");

    a_full_scatter_true: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!circ && !disabled_i && scatter_i) |=> buffer_full_flag_o == $past(mem_full_i))
        else $error("scatter full does not follow memory");

    // Software restore of the flag while parked must land exactly as written
    a_full_write_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (disabled_i && sts_wr) |=> buffer_full_flag_o == $past(reg_wdata_i[TBST_BIT_FULL]))
        else $error("full write not loaded while disabled");

endmodule

// >>> include/tbst_pkg.sv
// Package of offsets, fields, reset values and types for the trace buffer status block
package tbst_pkg;
    // Register byte offsets
    localparam logic [11:0] TBST_OFS_STATUS = 12'h00C;
    localparam logic [11:0] TBST_OFS_TRGCNT = 12'h01C;
    localparam int TBST_ADDR_W = 12;
    localparam int TBST_DATA_W = 32;

    // Status field positions
    localparam int TBST_BIT_FULL = 0;
    localparam int TBST_BIT_TRIGGERED = 1;
    localparam int TBST_BIT_IDLE = 2;
    localparam int TBST_BIT_DRAINED = 3;
    localparam int TBST_BIT_EMPTY = 4;

    // Operating mode encodings
    localparam logic [1:0] TBST_MODE_CIRCULAR = 2'h0;
    localparam logic [1:0] TBST_MODE_SWFIFO1 = 2'h1;

    // Reset values
    localparam logic TBST_RST_IDLE = 1'h1;
    localparam logic TBST_RST_EMPTY = 1'h0;
    localparam logic TBST_RST_FULL = 1'h0;
    localparam logic TBST_RST_DISABLED = 1'h1;
    localparam logic [31:0] TBST_RST_TRGCNT = 32'h0000_0000;

    // Register port answer latency in clock cycles
    localparam int TBST_ACK_CYCLES = 1;

    typedef enum logic [1:0] {
        TBST_TRG_IDLE,
        TBST_TRG_COUNT,
        TBST_TRG_DONE
    } tbst_trg_t;

    typedef struct packed {
        logic empty;
        logic drained;
        logic idle;
        logic trig;
        logic full;
        logic dis_q;
        tbst_trg_t tstate;
        logic [31:0] trg_cnt;
        logic [31:0] down;
        logic tevent;
        logic ack;
        logic [31:0] rdata;
    } tbst_state_t;
endpackage
